// ===== shared/lcs_pkg.sv
// Shared types and constants of the LCD scan-out block.
// Assumes one 125 MHz system clock and a synchronous active-high reset.
package lcs_pkg;

   // ************************************
   // Timing
   // ************************************
   localparam int CLK_PERIOD_PS = 8000;
   // Shortest dot clock period, 1 / 33.3 MHz.
   localparam int PIX_MIN_PERIOD_PS = 30030;
   localparam int PIX_MIN_CYC =
      (PIX_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int GAP_W = 3;

   // ************************************
   // Sizes and limits
   // ************************************
   localparam int DIV_W = 6;
   localparam logic [DIV_W-1:0] DIV_MIN = 6'h01;
   localparam logic [DIV_W-1:0] DIV_MAX = 6'h3c;
   localparam int POS_W = 11;
   localparam int AXW = 13;
   localparam logic [POS_W-1:0] H_MAX_NARROW = 11'h400;
   localparam logic [POS_W-1:0] H_MAX_WIDE = 11'h200;
   localparam logic [POS_W-1:0] V_MAX = 11'h400;
   localparam int ADDR_W = 32;
   localparam int STRIDE_W = 16;
   localparam int FETCH_W = 64;
   localparam int DATA_W = 24;
   localparam logic [DATA_W-1:0] DATA_IDLE = 24'h000000;
   localparam logic [GAP_W-1:0] GAP_RESET = 3'h7;

   // ************************************
   // Types
   // ************************************
   typedef enum logic [1:0] {
      SRC_BUS  = 2'b00,
      SRC_PERI = 2'b01,
      SRC_EXT  = 2'b10
   } lcs_src_t;

   typedef enum logic [2:0] {
      OUT_RGB8      = 3'b000,
      OUT_RGB9      = 3'b001,
      OUT_RGB12_TWO = 3'b010,
      OUT_RGB12_ONE = 3'b011,
      OUT_RGB16     = 3'b100,
      OUT_RGB18     = 3'b101,
      OUT_RGB24     = 3'b110
   } lcs_out_t;

   typedef enum logic [2:0] {
      IN_RGB565   = 3'b000,
      IN_RGB444   = 3'b001,
      IN_RGB888P3 = 3'b010,
      IN_RGB888P4 = 3'b011,
      IN_BGR888P4 = 3'b100,
      IN_YCC444   = 3'b101,
      IN_YCC422   = 3'b110,
      IN_YCC420   = 3'b111
   } lcs_in_t;

   typedef struct packed {
      logic [POS_W-1:0] front;
      logic [POS_W-1:0] sync;
      logic [POS_W-1:0] back;
      logic [POS_W-1:0] active;
   } lcs_timing_t;

   typedef struct packed {
      logic byte_swap;
      logic word_swap;
      logic long_swap;
   } lcs_swap_t;

endpackage : lcs_pkg

// ===== hw/lcs_scan_axis.sv
// One scan axis: position counter with front porch, sync, back porch, active.
// Assumes the advance strobe comes from logic on the same clock.
`timescale 1ns/10ps
module lcs_scan_axis (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                reset,
   // Control
   input  wire logic                restart,
   input  wire logic                advance,
   input  wire lcs_pkg::lcs_timing_t timing,
   // Status
   output logic                     in_sync,
   output logic                     in_active,
   output logic                     wrap
);
   import lcs_pkg::*;

   logic [AXW-1:0] pos;
   logic [AXW-1:0] end_front;
   logic [AXW-1:0] end_sync;
   logic [AXW-1:0] end_back;
   logic [AXW-1:0] end_total;

   assign end_front = AXW'(timing.front);
   assign end_sync  = end_front + AXW'(timing.sync);
   assign end_back  = end_sync + AXW'(timing.back);
   assign end_total = end_back + AXW'(timing.active);

   assign in_sync   = (pos >= end_front) && (pos < end_sync);
   assign in_active = (pos >= end_back) && (pos < end_total);
   assign wrap      = advance && (pos + 13'h0001 >= end_total);

   always_ff @(posedge clock) begin
      if (reset || restart) begin
         pos <= '0;
      end else if (advance) begin
         pos <= wrap ? '0 : pos + 13'h0001;
      end
   end

endmodule : lcs_scan_axis

// ===== hw/lcs_scanout.sv
// LCD frame scan-out: frame buffer fetch, dot clock divider, sync timing.
// Assumes a memory port that answers one read with fetch_ack, on this clock,
// returning eight bytes starting at fetch_addr, first byte in the top lane.
`timescale 1ns/10ps

// How it works
// - Pixels are fetched left to right from the base address.
// - After a full line the fetch moves to the next line start.
// - After the last line the fetch stops and restarts at the base.
// - Output data changes once per dot clock, on its falling edge.
// - Each line has front porch, one horizontal sync, back porch, no data.
// - Each frame has front porch, one vertical sync, back porch, no data.
// - No data between last pixel of a line and first of the next.
// - No data from last displayed line until the next frame starts.
// - Vertical sync is issued once per frame scan.
// - Two-byte pixel formats allow lines up to 1024 pixels.
// - Three and four byte formats allow lines up to 512 pixels.
// - Frames are limited to 1024 lines.
// - Packed RGB and BGR inputs are accepted; YCbCr formats read one byte per pixel, shown as grey.
// - Pixels take three, two or one dot clocks by output mode.
// - Sync polarity is chosen by configuration inputs.
// - Porch and sync widths are programmable per axis.
// - Dot clock comes from bus, peripheral or external clock.
// - Dot clock rising edges are spaced no closer than 33.3 MHz.
// - Divider ratio is one over any integer from 1 to 60.
// - Only integer division is possible; numerator is always one.
// - Byte, word and longword swaps apply to fetched data.
module lcs_scanout (
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          reset,
   // Configuration
   input  wire logic                          display_enable,
   input  wire lcs_pkg::lcs_src_t             clock_source,
   input  wire logic [lcs_pkg::DIV_W-1:0]     divide_ratio,
   input  wire lcs_pkg::lcs_in_t              input_format,
   input  wire lcs_pkg::lcs_out_t             output_mode,
   input  wire lcs_pkg::lcs_swap_t            swap,
   input  wire logic                          hsync_active_high,
   input  wire logic                          vsync_active_high,
   input  wire lcs_pkg::lcs_timing_t          h_timing,
   input  wire lcs_pkg::lcs_timing_t          v_timing,
   input  wire logic [lcs_pkg::ADDR_W-1:0]    base_address,
   input  wire logic [lcs_pkg::STRIDE_W-1:0]  line_stride,
   // Source clocks
   input  wire logic                          bus_clock_in,
   input  wire logic                          peripheral_clock_in,
   input  wire logic                          external_pixel_clock_in,
   // Memory read port
   output logic                               fetch_req,
   output logic [lcs_pkg::ADDR_W-1:0]         fetch_addr,
   input  wire logic                          fetch_ack,
   input  wire logic [lcs_pkg::FETCH_W-1:0]   fetch_data,
   // Panel
   output logic                               pixel_clock_out,
   output logic                               hsync,
   output logic                               vsync,
   output logic                               data_enable,
   output logic [lcs_pkg::DATA_W-1:0]         pixel_data,
   // Status
   input  wire logic                          underrun_clear,
   output logic                               underrun
);
   import lcs_pkg::*;

   // ************************************
   // Source clock sampling
   // ************************************
   logic [2:0]       src_s1;
   logic [2:0]       src_s2;
   logic             src_s3;
   logic             src_sel;
   logic             src_edge;

   always_ff @(posedge clock) begin
      if (reset) begin
         src_s1 <= 3'h0;
         src_s2 <= 3'h0;
         src_s3 <= 1'b0;
      end else begin
         src_s1 <= {external_pixel_clock_in, peripheral_clock_in, bus_clock_in};
         src_s2 <= src_s1;
         src_s3 <= src_sel;
      end
   end

   always_comb begin
      case (clock_source)
         SRC_BUS:  src_sel = src_s2[0];
         SRC_PERI: src_sel = src_s2[1];
         SRC_EXT:  src_sel = src_s2[2];
         default:  src_sel = src_s2[0];
      endcase
   end

   // Both edges count, so a ratio of one still gives a full clock.
   assign src_edge = src_sel != src_s3;

   // ************************************
   // Dot clock divider
   // ************************************
   logic [DIV_W-1:0] div_eff;
   logic [DIV_W-1:0] half_cnt;
   logic             hold_term;
   logic [GAP_W-1:0] gap;
   logic             gap_ok;
   logic             at_term;
   logic             fire;
   logic             step;

   always_comb begin
      if (divide_ratio < DIV_MIN) begin
         div_eff = DIV_MIN;
      end else if (divide_ratio > DIV_MAX) begin
         div_eff = DIV_MAX;
      end else begin
         div_eff = divide_ratio;
      end
   end

   assign at_term = half_cnt == div_eff - 6'h01;
   assign gap_ok  = gap >= GAP_W'(PIX_MIN_CYC - 1);
   // A rise waits until enough cycles passed since the last one.
   assign fire    = ((src_edge && at_term) || hold_term)
                    && (pixel_clock_out || gap_ok);
   assign step    = fire && pixel_clock_out;

   always_ff @(posedge clock) begin
      if (reset || !display_enable) begin
         half_cnt  <= '0;
         hold_term <= 1'b0;
      end else if (fire) begin
         half_cnt  <= '0;
         hold_term <= 1'b0;
      end else if (src_edge) begin
         if (at_term) begin
            hold_term <= 1'b1;
         end else begin
            half_cnt <= half_cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset || !display_enable) begin
         pixel_clock_out <= 1'b0;
      end else if (fire) begin
         pixel_clock_out <= !pixel_clock_out;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         gap <= GAP_RESET;
      end else if (fire && !pixel_clock_out) begin
         gap <= '0;
      end else if (gap != GAP_RESET) begin
         gap <= gap + 3'h1;
      end
   end

   a_pclk_rise_gap: assert property (@(posedge clock) disable iff (reset)
      $rose(pixel_clock_out) |-> $past(gap) >= GAP_W'(PIX_MIN_CYC - 1))
      else $error("dot clock rising edges too close");

   a_div_range: assert property (@(posedge clock) disable iff (reset)
      divide_ratio >= DIV_MIN && divide_ratio <= DIV_MAX |-> div_eff == divide_ratio)
      else $error("divider ratio in range not used as given");

   // ************************************
   // Pixel slot and scan timing
   // ************************************
   logic [1:0] cyc_per_pix;
   logic [1:0] phase;
   logic       slot_end;
   logic       h_sync;
   logic       h_act;
   logic       h_wrap;
   logic       v_sync;
   logic       v_act;
   logic       v_wrap;
   logic       shown;

   always_comb begin
      case (output_mode)
         OUT_RGB8:      cyc_per_pix = 2'h3;
         OUT_RGB9:      cyc_per_pix = 2'h2;
         OUT_RGB12_TWO: cyc_per_pix = 2'h2;
         default:       cyc_per_pix = 2'h1;
      endcase
   end

   assign slot_end = phase >= cyc_per_pix - 2'h1;

   always_ff @(posedge clock) begin
      if (reset || !display_enable) begin
         phase <= 2'h0;
      end else if (step) begin
         phase <= slot_end ? 2'h0 : phase + 2'h1;
      end
   end

   a_phase_bound: assert property (@(posedge clock) disable iff (reset)
      phase < cyc_per_pix)
      else $error("pixel phase beyond cycles per pixel");

   lcs_scan_axis u_h_axis (
      .clock     (clock),
      .reset     (reset),
      .restart   (!display_enable),
      .advance   (step && slot_end),
      .timing    (h_timing),
      .in_sync   (h_sync),
      .in_active (h_act),
      .wrap      (h_wrap)
   );

   lcs_scan_axis u_v_axis (
      .clock     (clock),
      .reset     (reset),
      .restart   (!display_enable),
      .advance   (h_wrap),
      .timing    (v_timing),
      .in_sync   (v_sync),
      .in_active (v_act),
      .wrap      (v_wrap)
   );

   assign shown = h_act && v_act;

   // ************************************
   // Frame buffer fetch
   // ************************************
   logic [2:0]          bpp;
   logic [POS_W-1:0]    h_limit;
   logic [POS_W-1:0]    h_size;
   logic [POS_W-1:0]    v_size;
   logic [POS_W-1:0]    x_cnt;
   logic [POS_W-1:0]    y_cnt;
   logic [ADDR_W-1:0]   line_base;
   logic                restart_pend;
   logic                frame_done;
   logic                hold_valid;
   logic [DATA_W-1:0]   hold_pix;
   logic                consume;
   logic                line_last;
   logic [FETCH_W-1:0]  swapped;
   logic [31:0]         top;
   logic [DATA_W-1:0]   next_pix;

   always_comb begin
      case (input_format)
         IN_RGB565:   bpp = 3'h2;
         IN_RGB444:   bpp = 3'h2;
         IN_RGB888P3: bpp = 3'h3;
         IN_RGB888P4: bpp = 3'h4;
         IN_BGR888P4: bpp = 3'h4;
         default:     bpp = 3'h1;
      endcase
   end

   assign h_limit = (bpp > 3'h2) ? H_MAX_WIDE : H_MAX_NARROW;
   assign h_size  = (h_timing.active > h_limit) ? h_limit : h_timing.active;
   assign v_size  = (v_timing.active > V_MAX) ? V_MAX : v_timing.active;
   assign line_last = x_cnt + 11'h001 >= h_size;

   always_comb begin
      swapped = fetch_data;
      if (swap.long_swap) begin
         swapped = {swapped[31:0], swapped[63:32]};
      end
      if (swap.word_swap) begin
         swapped = {swapped[47:32], swapped[63:48], swapped[15:0], swapped[31:16]};
      end
      if (swap.byte_swap) begin
         swapped = {swapped[55:48], swapped[63:56], swapped[39:32], swapped[47:40],
                    swapped[23:16], swapped[31:24], swapped[7:0], swapped[15:8]};
      end
   end

   assign top = swapped[63:32];

   always_comb begin
      case (input_format)
         IN_RGB565:   next_pix = {top[31:27], 3'h0, top[26:21], 2'h0, top[20:16], 3'h0};
         IN_RGB444:   next_pix = {top[27:24], 4'h0, top[23:20], 4'h0, top[19:16], 4'h0};
         IN_RGB888P3: next_pix = top[31:8];
         IN_RGB888P4: next_pix = top[23:0];
         IN_BGR888P4: next_pix = {top[7:0], top[15:8], top[23:16]};
         default:     next_pix = {top[31:24], top[31:24], top[31:24]};
      endcase
   end

   assign consume = step && phase == 2'h0 && shown && hold_valid;

   always_ff @(posedge clock) begin
      if (reset || !display_enable) begin
         restart_pend <= 1'b1;
      end else if (v_wrap) begin
         restart_pend <= 1'b1;
      end else if (!fetch_req) begin
         restart_pend <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         fetch_req  <= 1'b0;
         fetch_addr <= '0;
         line_base  <= '0;
         x_cnt      <= '0;
         y_cnt      <= '0;
         frame_done <= 1'b1;
      end else if (restart_pend && !fetch_req) begin
         fetch_addr <= base_address;
         line_base  <= base_address;
         x_cnt      <= '0;
         y_cnt      <= '0;
         frame_done <= !display_enable || h_size == '0 || v_size == '0;
      end else if (fetch_req && fetch_ack) begin
         fetch_req <= 1'b0;
         if (line_last) begin
            x_cnt      <= '0;
            fetch_addr <= line_base + ADDR_W'(line_stride);
            line_base  <= line_base + ADDR_W'(line_stride);
            y_cnt      <= y_cnt + 11'h001;
            frame_done <= y_cnt + 11'h001 >= v_size;
         end else begin
            x_cnt      <= x_cnt + 11'h001;
            fetch_addr <= fetch_addr + ADDR_W'(bpp);
         end
      end else if (!fetch_req && !hold_valid && !frame_done && !restart_pend) begin
         fetch_req <= 1'b1;
      end
   end

   a_fetch_step: assert property (@(posedge clock) disable iff (reset)
      fetch_req && fetch_ack && !line_last && !restart_pend
      |=> fetch_addr == $past(fetch_addr) + ADDR_W'($past(bpp)))
      else $error("fetch address did not step by one pixel");

   a_line_wrap: assert property (@(posedge clock) disable iff (reset)
      fetch_req && fetch_ack && line_last && !restart_pend
      |=> x_cnt == '0 && fetch_addr == $past(line_base) + ADDR_W'($past(line_stride)))
      else $error("fetch did not move to next line start");

   a_frame_restart: assert property (@(posedge clock) disable iff (reset)
      restart_pend && !fetch_req && display_enable
      |=> fetch_addr == $past(base_address) && y_cnt == '0)
      else $error("frame fetch did not restart at base");

   always_ff @(posedge clock) begin
      if (reset || !display_enable) begin
         hold_valid <= 1'b0;
         hold_pix   <= DATA_IDLE;
      end else if (fetch_req && fetch_ack) begin
         hold_valid <= 1'b1;
         hold_pix   <= next_pix;
      end else if (consume) begin
         hold_valid <= 1'b0;
      end
   end

   // ************************************
   // Panel output
   // ************************************
   logic [DATA_W-1:0] cur_pix;
   logic [DATA_W-1:0] slot_pix;
   logic [DATA_W-1:0] next_data;

   assign slot_pix = (phase == 2'h0) ? hold_pix : cur_pix;

   always_comb begin
      case (output_mode)
         OUT_RGB8: begin
            case (phase)
               2'h0:    next_data = {16'h0000, slot_pix[23:16]};
               2'h1:    next_data = {16'h0000, slot_pix[15:8]};
               default: next_data = {16'h0000, slot_pix[7:0]};
            endcase
         end
         OUT_RGB9: next_data = (phase == 2'h0)
            ? {15'h0000, slot_pix[23:18], slot_pix[15:13]}
            : {15'h0000, slot_pix[12:10], slot_pix[7:2]};
         OUT_RGB12_TWO: next_data = (phase == 2'h0)
            ? {12'h000, slot_pix[23:12]}
            : {12'h000, slot_pix[11:0]};
         OUT_RGB12_ONE: next_data = {12'h000, slot_pix[23:20], slot_pix[15:12], slot_pix[7:4]};
         OUT_RGB16: next_data = {8'h00, slot_pix[23:19], slot_pix[15:10], slot_pix[7:3]};
         OUT_RGB18: next_data = {6'h00, slot_pix[23:18], slot_pix[15:10], slot_pix[7:2]};
         default:   next_data = slot_pix;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset || !display_enable) begin
         cur_pix <= DATA_IDLE;
      end else if (consume) begin
         cur_pix <= hold_pix;
      end
   end

   // A missing pixel sends idle data with data_enable high on its first dot clock, later ones of its slot repeat the last pixel, line timing intact.
   always_ff @(posedge clock) begin
      if (reset || !display_enable) begin
         data_enable <= 1'b0;
         pixel_data  <= DATA_IDLE;
      end else if (step) begin
         data_enable <= shown;
         if (shown && (phase != 2'h0 || hold_valid)) begin
            pixel_data <= next_data;
         end else begin
            pixel_data <= DATA_IDLE;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset || !display_enable) begin
         hsync <= !hsync_active_high;
         vsync <= !vsync_active_high;
      end else if (step) begin
         hsync <= h_sync ? hsync_active_high : !hsync_active_high;
         vsync <= v_sync ? vsync_active_high : !vsync_active_high;
      end
   end

   a_blank_data_idle: assert property (@(posedge clock) disable iff (reset)
      !data_enable |-> pixel_data == DATA_IDLE)
      else $error("pixel data not idle during blanking");

   a_hsync_no_data: assert property (@(posedge clock) disable iff (reset)
      hsync == hsync_active_high && $stable(hsync_active_high) |-> !data_enable)
      else $error("data shown during horizontal sync");

   a_vsync_no_data: assert property (@(posedge clock) disable iff (reset)
      vsync == vsync_active_high && $stable(vsync_active_high) |-> !data_enable)
      else $error("data shown during vertical sync");

   a_data_on_fall: assert property (@(posedge clock) disable iff (reset)
      $changed(pixel_data) && display_enable |-> $fell(pixel_clock_out))
      else $error("pixel data changed away from dot clock fall");

   // ************************************
   // Status
   // ************************************
   always_ff @(posedge clock) begin
      if (reset) begin
         underrun <= 1'b0;
      end else if (step && phase == 2'h0 && shown && !hold_valid) begin
         underrun <= 1'b1;
      end else if (underrun_clear) begin
         underrun <= 1'b0;
      end
   end

endmodule : lcs_scanout

// ===== test/lcs_panel_model.sv
// Panel model: samples the RGB interface on each dot clock rise.
// Assumes sync, enable and data settle on the dot clock fall.
`timescale 1ns/10ps
module lcs_panel_model (
   // Panel pins
   input  wire logic                        pixel_clock_out,
   input  wire logic                        hsync,
   input  wire logic                        vsync,
   input  wire logic                        data_enable,
   input  wire logic [lcs_pkg::DATA_W-1:0]  pixel_data,
   input  wire logic                        hs_high,
   input  wire logic                        vs_high,
   // Observations
   output int                               pix_count,
   output logic [lcs_pkg::DATA_W-1:0]       pix_last,
   output int                               frame_lines,
   output int                               frame_count,
   output int                               blank_dirty
);
   import lcs_pkg::*;
   int   line_acc = 0;
   logic hs_prev  = 1'b0;
   logic vs_prev  = 1'b0;
   initial begin
      pix_count   = 0;
      pix_last    = DATA_IDLE;
      frame_lines = 0;
      frame_count = 0;
      blank_dirty = 0;
   end
   // A real panel only latches on the rise, so glitches between rises pass unseen.
   always @(posedge pixel_clock_out) begin
      hs_prev <= (hsync === hs_high);
      vs_prev <= (vsync === vs_high);
      if (data_enable === 1'b1) begin
         pix_last  <= pixel_data;
         pix_count <= pix_count + 1;
      end else if (pixel_data !== DATA_IDLE) begin
         blank_dirty <= blank_dirty + 1;
      end
      if ((vsync === vs_high) && !vs_prev) begin
         frame_lines <= line_acc;
         frame_count <= frame_count + 1;
         line_acc    <= ((hsync === hs_high) && !hs_prev) ? 1 : 0;
      end else if ((hsync === hs_high) && !hs_prev) begin
         line_acc <= line_acc + 1;
      end
   end
endmodule : lcs_panel_model

// ===== test/tb_top.sv
// Testbench: drives the scan-out with memory and source clocks, checks panel output.
// Assumes the panel model in its own file and a one-cycle memory answer.
`timescale 1ns/10ps
module tb_top;
   import lcs_pkg::*;
   // ************************************
   // Stimulus and wiring
   // ************************************
   logic clock = 1'b0, reset = 1'b1, en = 1'b0, hs_hi = 1'b1, vs_hi = 1'b1;
   logic bus_clk = 1'b0, peri_clk = 1'b0, ext_clk = 1'b0, req, ack = 1'b0, dclk, hs, vs, de, urun;
   lcs_src_t src = SRC_BUS;
   lcs_in_t fmt = IN_RGB888P4;
   lcs_out_t mode = OUT_RGB24;
   lcs_swap_t swp = '0;
   logic [DIV_W-1:0] ratio = 6'h01;
   logic [31:0] base = 32'h0, addr, seed = 32'he9be;
   logic [15:0] stride = 16'h0020;
   logic [63:0] fdata = 64'h0;
   logic [DATA_W-1:0] pix, plast;
   logic [DATA_W-1:0] exp_q[$];
   int err_count = 0, num_checks = 0, pcount, flines, fcount, dirty, seen, gap = 0, fc0, per = 0;
   logic dprev = 1'b0;
   always #4 clock = ~clock;
   always #40 bus_clk = ~bus_clk;
   always #48 peri_clk = ~peri_clk;
   always #56 ext_clk = ~ext_clk;
   lcs_scanout i_lcs_scanout (.clock(clock), .reset(reset), .display_enable(en), .clock_source(src),
      .divide_ratio(ratio), .input_format(fmt), .output_mode(mode), .swap(swp),
      .hsync_active_high(hs_hi), .vsync_active_high(vs_hi), .h_timing({11'h002, 11'h002, 11'h002, 11'h008}),
      .v_timing({11'h001, 11'h001, 11'h001, 11'h003}), .base_address(base), .line_stride(stride),
      .bus_clock_in(bus_clk), .peripheral_clock_in(peri_clk), .external_pixel_clock_in(ext_clk),
      .fetch_req(req), .fetch_addr(addr), .fetch_ack(ack), .fetch_data(fdata), .pixel_clock_out(dclk),
      .hsync(hs), .vsync(vs), .data_enable(de), .pixel_data(pix), .underrun_clear(1'b0), .underrun(urun));
   lcs_panel_model i_lcs_panel_model (.pixel_clock_out(dclk), .hsync(hs), .vsync(vs), .data_enable(de),
      .pixel_data(pix), .hs_high(hs_hi), .vs_high(vs_hi), .pix_count(pcount), .pix_last(plast),
      .frame_lines(flines), .frame_count(fcount), .blank_dirty(dirty));
   // ************************************
   // Memory and reference model
   // ************************************
   function automatic logic [7:0] mem_byte(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction : mem_byte
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   always @(posedge clock) begin
      ack <= req && !ack;
      for (int k = 0; k < 8; k++) begin
         fdata[63-8*k -: 8] <= mem_byte(addr + k);
      end
   end
   // Dot clock rises are timed in system cycles.
   always @(posedge clock) begin
      dprev <= dclk;
      gap   <= (dclk && !dprev) ? 0 : gap + 1;
      if (dclk && !dprev && !reset) check_num("dot_rise_spacing", 1, int'(gap >= 3));
      if (dclk && !dprev && de) check_num("dot_period", per, gap + 1);
   end
   // ************************************
   // Checks
   // ************************************
   task automatic check_pix(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected pixel_data expected %h seen %h", e, s);
      end
   endtask : check_pix
   task automatic check_num(input string n, input int e, input int s);
      num_checks++;
      if (s != e) begin
         err_count++;
         $display("unexpected %s expected %0d seen %0d", n, e, s);
      end
   endtask : check_num
   task automatic conclude();
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // ************************************
   // Runs: two frames for each source clock, ratio and polarity
   // ************************************
   task automatic run(input lcs_src_t s, input logic [DIV_W-1:0] r, input logic pol, input lcs_in_t fi,
         input lcs_out_t om, input logic bs);
      logic [31:0] a;
      @(posedge clock);
      en <= 1'b0;
      src <= s;
      ratio <= r;
      hs_hi <= pol;
      vs_hi <= ~pol;
      seed = lfsr(seed);
      base <= {3'b000, seed[25:0], 3'b000};
      stride <= {10'h000, seed[5:3], 3'b000} + 16'h0020;
      repeat (4) @(posedge clock);
      exp_q.delete();
      for (int f = 0; f < 2; f++) begin
         for (int l = 0; l < 3; l++) begin
            for (int x = 0; x < 8; x++) begin
               a = base + l * stride + ((fi == IN_RGB565) ? 2 * x : 4 * x);
               if (fi == IN_RGB565) exp_q.push_back(bs ? {8'h00, mem_byte(a + 1), mem_byte(a)}
                                                       : {8'h00, mem_byte(a), mem_byte(a + 1)});
               else if (om == OUT_RGB8) for (int k = 1; k < 4; k++) exp_q.push_back({16'h0000, mem_byte(a + k)});
               else exp_q.push_back({mem_byte(a + 1), mem_byte(a + 2), mem_byte(a + 3)});
            end
         end
      end
      seen = pcount;
      fc0 = fcount;
      fmt <= fi;
      mode <= om;
      swp <= {bs, 2'b00};
      per = 2 * int'(r) * ((s == SRC_BUS) ? 5 : (s == SRC_PERI) ? 6 : 7);
      en <= 1'b1;
      for (int t = 0; t < 20000 && exp_q.size() > 0; t++) begin
         @(negedge clock);
         if (pcount != seen) begin
            seen = pcount;
            check_pix(exp_q.pop_front(), plast);
         end
      end
      if (exp_q.size() > 0) check_num("pixels_left", 0, exp_q.size());
      check_num("lines_per_frame", 6, flines);
      check_num("vsyncs_per_run", 2, fcount - fc0);
      check_num("blank_data", 0, dirty);
      check_num("underrun", 0, int'(urun !== 1'b0));
   endtask : run
   initial begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      run(SRC_BUS, 6'h01, 1'b1, IN_RGB888P4, OUT_RGB8, 1'b0);
      run(SRC_PERI, 6'h02, 1'b0, IN_RGB565, OUT_RGB16, 1'b1);
      run(SRC_EXT, 6'h03, 1'b1, IN_RGB888P4, OUT_RGB24, 1'b0);
      conclude();
   end
endmodule : tb_top
